// ### code_overlay_regs.svh
// control codes, field masks, decode offsets and reset values
`ifndef CODE_OVERLAY_REGS_SVH
`define CODE_OVERLAY_REGS_SVH
`define CTL_SRC_FC      12'h000
`define CTL_DST_FC      12'h001
`define CTL_USER_SP     12'h800
`define CTL_VEC_BASE    12'h801
`define CTL_LOCK        12'hffe
`define CTL_BASE_OFS    12'hfff
`define FC_MASK         32'h0000_0007
`define VEC_BASE_MASK   32'hffff_fc00
`define LOCK_MASK       32'h0000_0001
`define LOCK_BIT        0
`define BASE_OFS_MASK   32'hfff0_0000
`define BASE_OFS_RESET  32'h0010_0000
`define SEGC_MASK       32'hffff_f801
`define SEG_EN_BIT      0
`define OVL_REGION      5'h10
`define SRAM_REGION     5'h00
`define SRAM_WORD_END   13'h1800
`define SEGC_BLOCK      14'h2848
`define MASTER_CTX      3'h0
`endif

// ### code_overlay_pkg.sv
// types shared by the code overlay block and its users
package code_overlay_pkg;
  typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} acc_size_t;
  typedef struct packed {
    logic        we;
    acc_size_t   size;
    logic [31:0] addr;
    logic [31:0] data;
  } acc_t;
  typedef enum logic [1:0] {ST_IDLE, ST_EXT, ST_DONE} bus_state_t;
endpackage

// ### code_overlay_and_endian_swap.sv
// code overlay decode, byte-order swap and control-move registers
`timescale 1ns/100ps
`include "code_overlay_regs.svh"
module code_overlay_and_endian_swap #(
  parameter int          NUM_CTX        = 5,
  parameter int          NUM_SEG        = 16,
  parameter int          SEG_WORDS      = 512,
  parameter int          SRAM_WORDS     = 6144,
  parameter logic [31:0] USP_RESET_BASE = 32'h0000_0000,
  parameter logic [31:0] USP_RESET_STEP = 32'h0000_0000
) (
  input  wire logic                    clk_sys,
  input  wire logic                    rst,
  input  wire logic                    minor_rst,
  input  wire logic                    fetch_req,
  input  wire logic [31:0]             fetch_addr,
  input  wire logic                    fetch_cont,
  output logic                         fetch_ack,
  output logic                         fetch_fault,
  output logic [31:0]                  fetch_data,
  input  wire logic                    op_req,
  input  wire code_overlay_pkg::acc_t  op_acc,
  input  wire logic [2:0]              op_ctx,
  output logic                         op_ack,
  output logic                         op_err,
  output logic [31:0]                  op_rdata,
  input  wire logic                    ctl_req,
  input  wire logic                    ctl_we,
  input  wire logic [11:0]             ctl_code,
  input  wire logic [2:0]              ctl_ctx,
  input  wire logic [31:0]             ctl_wdata,
  output logic                         ctl_ack,
  output logic                         ctl_err,
  output logic [31:0]                  ctl_rdata,
  output logic                         ext_req,
  output logic                         ext_we,
  output code_overlay_pkg::acc_size_t  ext_size,
  output logic [30:0]                  ext_addr,
  output logic [31:0]                  ext_wdata,
  input  wire logic                    ext_ack,
  input  wire logic [31:0]             ext_rdata
);
  import code_overlay_pkg::*;

  // reverse lanes for bit-31 accesses; bytes pass untouched
  function automatic logic [31:0] order_fix(input logic [31:0] d,
      input acc_size_t sz, input logic flip);
    order_fix = d;
    if (flip && sz == SZ_WORD)
      order_fix = {d[23:16], d[31:24], d[7:0], d[15:8]};
    else if (flip && sz == SZ_LONG)
      order_fix = {d[7:0], d[15:8], d[23:16], d[31:24]};
  endfunction

  // byte enables; lane 3 holds the lowest address
  function automatic logic [3:0] lanes(input acc_size_t sz,
      input logic [1:0] a);
    lanes = 4'hf;
    if (sz == SZ_BYTE)
      lanes = 4'h8 >> a;
    else if (sz == SZ_WORD)
      lanes = a[1] ? 4'h3 : 4'hc;
  endfunction

  logic [31:0] ovl_mem [NUM_SEG*SEG_WORDS];  // overlay code store
  logic [31:0] sram [SRAM_WORDS];            // data memory
  logic [31:0] segc [NUM_SEG];               // segment controls
  logic [31:0] source_function_code [NUM_CTX];
  logic [31:0] destination_function_code [NUM_CTX];
  logic [31:0] user_stack_pointer [NUM_CTX];
  logic [31:0] vector_table_base [NUM_CTX];
  logic [31:0] config_write_lock;
  logic [31:0] internal_base_offset;

  bus_state_t  state, next_state;   // core-side handshake state
  logic        for_fetch;           // external cycle belongs to fetch
  logic        next_for_fetch;
  logic        last_int;            // previous fetch came from inside
  logic        next_last_int;
  acc_size_t   pend_size;           // size of pending external access
  logic        pend_flip;           // pending access is byte-reversed
  logic        next_fetch_ack, next_fetch_fault, next_op_ack;
  logic        next_op_err, next_ext_req, next_ext_we;
  logic [31:0] next_fetch_data, next_op_rdata, next_ext_wdata;
  logic [30:0] next_ext_addr;
  acc_size_t   next_ext_size;
  logic        ovl_we, sram_we, segc_we;
  logic [3:0]  mem_be;               // byte lanes of a memory write
  logic [31:0] mem_wdata;            // swapped write data

  // decode of the access picked this cycle
  acc_t        cur;                  // fetch wins over operand
  logic        flip;                 // byte-reversed region
  logic        internal;             // hits relocated internal space
  logic        in_ovl, in_sram, in_segc;
  logic [NUM_SEG-1:0] seg_hit;       // fetch falls in enabled window
  logic        seg_any;
  logic [3:0]  seg_sel;              // lowest matching segment
  logic        any_en;               // at least one segment enabled
  logic        src_int;              // fetch is served internally
  logic [12:0] ovl_idx;
  logic [12:0] word_idx;

  assign cur = fetch_req ? acc_t'{we: 1'b0, size: SZ_LONG,
                                  addr: fetch_addr, data: 32'h0} : op_acc;
  assign flip = cur.addr[31];
  // offsets are or-ed with the base, so match bits 30..20
  assign internal = cur.addr[30:20] == internal_base_offset[30:20];
  assign in_ovl = internal && cur.addr[19:15] == `OVL_REGION;
  assign in_sram = internal && cur.addr[19:15] == `SRAM_REGION
                   && cur.addr[14:2] < `SRAM_WORD_END;
  assign in_segc = internal && cur.addr[19:6] == `SEGC_BLOCK;
  assign word_idx = cur.addr[14:2];

  // window compare for every segment
  genvar g;
  generate
    for (g = 0; g < NUM_SEG; g++) begin : gen_seg
      assign seg_hit[g] = segc[g][`SEG_EN_BIT]
                          && fetch_addr[30:11] == segc[g][30:11];
    end
  endgenerate
  assign seg_any = |seg_hit;

  // any enable, gathered from the enable bits
  always_comb begin
    any_en = 1'b0;
    for (int i = 0; i < NUM_SEG; i++)
      any_en = any_en | segc[i][`SEG_EN_BIT];
  end

  // scan downward so the lowest number is left standing
  always_comb begin
    seg_sel = 4'h0;
    for (int i = NUM_SEG - 1; i >= 0; i--)
      if (seg_hit[i])
        seg_sel = 4'(i);
  end
  assign ovl_idx = seg_any ? {seg_sel, fetch_addr[10:2]} : word_idx;
  assign src_int = seg_any || internal;

  // handshake: take one access, answer inside or go outside
  always_comb begin
    next_state = state;
    next_for_fetch = for_fetch;
    next_last_int = last_int;
    next_fetch_ack = 1'b0;
    next_fetch_fault = 1'b0;
    next_fetch_data = fetch_data;
    next_op_ack = 1'b0;
    next_op_err = 1'b0;
    next_op_rdata = op_rdata;
    next_ext_req = ext_req;
    next_ext_we = ext_we;
    next_ext_size = ext_size;
    next_ext_addr = ext_addr;
    next_ext_wdata = ext_wdata;
    ovl_we = 1'b0;
    sram_we = 1'b0;
    segc_we = 1'b0;
    mem_be = lanes(cur.size, cur.addr[1:0]);
    mem_wdata = order_fix(cur.data, cur.size, flip);
    unique case (state)
      ST_IDLE: begin
        if (fetch_req) begin
          next_fetch_ack = src_int;
          next_state = src_int ? ST_DONE : ST_EXT;
          if (fetch_cont && src_int != last_int) begin
            // one instruction split across two sources
            next_fetch_ack = 1'b1;
            next_fetch_fault = 1'b1;
            next_state = ST_DONE;
          end else if (seg_any || in_ovl) begin
            next_last_int = 1'b1;
            next_fetch_data = order_fix(ovl_mem[ovl_idx], SZ_LONG, flip);
          end else if (in_sram) begin
            next_last_int = 1'b1;
            next_fetch_data = order_fix(sram[word_idx], SZ_LONG, flip);
          end else if (internal) begin
            // register space holds no code
            next_fetch_fault = 1'b1;
          end else begin
            next_last_int = 1'b0;
            next_for_fetch = 1'b1;
            next_ext_req = 1'b1;
            next_ext_we = 1'b0;
            next_ext_size = SZ_LONG;
            next_ext_addr = cur.addr[30:0];
          end
        end else if (op_req) begin
          next_op_ack = internal;
          next_state = internal ? ST_DONE : ST_EXT;
          if (in_segc) begin
            next_op_rdata = segc[cur.addr[5:2]];
            // master only, and only while unlocked
            if (cur.we && op_ctx == `MASTER_CTX
                && !config_write_lock[`LOCK_BIT])
              segc_we = 1'b1;
            else if (cur.we)
              next_op_err = 1'b1;
          end else if (in_ovl) begin
            // once enabled the overlay is no operand space
            if (any_en)
              next_op_err = 1'b1;
            else begin
              ovl_we = cur.we;
              next_op_rdata = order_fix(ovl_mem[word_idx], cur.size, flip);
            end
          end else if (in_sram) begin
            sram_we = cur.we;
            next_op_rdata = order_fix(sram[word_idx], cur.size, flip);
          end else if (internal) begin
            next_op_err = 1'b1;
          end else begin
            next_for_fetch = 1'b0;
            next_ext_req = 1'b1;
            next_ext_we = cur.we;
            next_ext_size = cur.size;
            next_ext_addr = cur.addr[30:0];
            next_ext_wdata = mem_wdata;
          end
        end
      end
      ST_EXT: begin
        if (ext_ack) begin
          next_ext_req = 1'b0;
          next_state = ST_DONE;
          if (for_fetch) begin
            next_fetch_ack = 1'b1;
            next_fetch_data = order_fix(ext_rdata, SZ_LONG, pend_flip);
          end else begin
            next_op_ack = 1'b1;
            next_op_rdata = order_fix(ext_rdata, pend_size, pend_flip);
          end
        end
      end
      ST_DONE: next_state = ST_IDLE;
    endcase
  end

  // handshake flops; a minor reset also restarts them
  always_ff @(posedge clk_sys) begin
    if (rst || minor_rst) begin
      state <= ST_IDLE;
      for_fetch <= 1'b0;
      last_int <= 1'b0;
      pend_size <= SZ_BYTE;
      pend_flip <= 1'b0;
      fetch_ack <= 1'b0;
      fetch_fault <= 1'b0;
      fetch_data <= 32'h0;
      op_ack <= 1'b0;
      op_err <= 1'b0;
      op_rdata <= 32'h0;
      ext_req <= 1'b0;
      ext_we <= 1'b0;
      ext_size <= SZ_BYTE;
      ext_addr <= 31'h0;
      ext_wdata <= 32'h0;
    end else begin
      state <= next_state;
      for_fetch <= next_for_fetch;
      last_int <= next_last_int;
      if (state == ST_IDLE) begin
        pend_size <= cur.size;
        pend_flip <= flip;
      end
      fetch_ack <= next_fetch_ack;
      fetch_fault <= next_fetch_fault;
      fetch_data <= next_fetch_data;
      op_ack <= next_op_ack;
      op_err <= next_op_err;
      op_rdata <= next_op_rdata;
      ext_req <= next_ext_req;
      ext_we <= next_ext_we;
      ext_size <= next_ext_size;
      ext_addr <= next_ext_addr;
      ext_wdata <= next_ext_wdata;
    end
  end

  // memory writes, lane by lane; contents survive resets
  always_ff @(posedge clk_sys) begin
    for (int b = 0; b < 4; b++) begin
      if (ovl_we && mem_be[b])
        ovl_mem[word_idx][b*8 +: 8] <= mem_wdata[b*8 +: 8];
      if (sram_we && mem_be[b])
        sram[word_idx][b*8 +: 8] <= mem_wdata[b*8 +: 8];
    end
  end

  // control-move port decode
  logic ctx_ok, is_master;
  logic next_ctl_ack, next_ctl_err;
  logic [31:0] next_ctl_rdata;
  logic wr_sfc, wr_dfc, wr_usp, wr_vec, wr_lock, wr_ofs;
  assign ctx_ok = 32'(ctl_ctx) < NUM_CTX;
  assign is_master = ctl_ctx == `MASTER_CTX;

  always_comb begin
    next_ctl_ack = ctl_req && !ctl_ack;
    next_ctl_err = 1'b0;
    next_ctl_rdata = ctl_rdata;
    {wr_sfc, wr_dfc, wr_usp, wr_vec, wr_lock, wr_ofs} = 6'h0;
    if (next_ctl_ack && !ctx_ok)
      next_ctl_err = 1'b1;
    else if (next_ctl_ack) begin
      case (ctl_code)
        `CTL_SRC_FC: begin
          next_ctl_rdata = source_function_code[ctl_ctx];
          wr_sfc = ctl_we;
        end
        `CTL_DST_FC: begin
          next_ctl_rdata = destination_function_code[ctl_ctx];
          wr_dfc = ctl_we;
        end
        `CTL_USER_SP: begin
          next_ctl_rdata = user_stack_pointer[ctl_ctx];
          wr_usp = ctl_we;
        end
        `CTL_VEC_BASE: begin
          next_ctl_rdata = vector_table_base[ctl_ctx];
          wr_vec = ctl_we;
        end
        `CTL_LOCK: begin
          next_ctl_err = !is_master;
          next_ctl_rdata = is_master ? config_write_lock : 32'h0;
          wr_lock = ctl_we && is_master;
        end
        `CTL_BASE_OFS: begin
          next_ctl_err = !is_master;
          next_ctl_rdata = is_master ? internal_base_offset : 32'h0;
          wr_ofs = ctl_we && is_master;
        end
        default: next_ctl_err = 1'b1;
      endcase
    end
  end

  // configuration flops: only the major reset loads their reset values
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int i = 0; i < NUM_CTX; i++) begin
        source_function_code[i] <= 32'h0;
        destination_function_code[i] <= 32'h0;
        user_stack_pointer[i] <= USP_RESET_BASE
                                 + USP_RESET_STEP * 32'(i);
        vector_table_base[i] <= 32'h0;
      end
      for (int s = 0; s < NUM_SEG; s++)
        segc[s] <= 32'h0;
      config_write_lock <= 32'h0;
      internal_base_offset <= `BASE_OFS_RESET;
      ctl_ack <= 1'b0;
      ctl_err <= 1'b0;
      ctl_rdata <= 32'h0;
    end else begin
      ctl_ack <= next_ctl_ack;
      ctl_err <= next_ctl_err;
      ctl_rdata <= next_ctl_rdata;
      if (wr_sfc)
        source_function_code[ctl_ctx] <= ctl_wdata & `FC_MASK;
      if (wr_dfc)
        destination_function_code[ctl_ctx] <= ctl_wdata & `FC_MASK;
      if (wr_usp)
        user_stack_pointer[ctl_ctx] <= ctl_wdata;
      if (wr_vec)
        vector_table_base[ctl_ctx] <= ctl_wdata & `VEC_BASE_MASK;
      if (wr_lock)
        config_write_lock <= ctl_wdata & `LOCK_MASK;
      if (wr_ofs)
        internal_base_offset <= ctl_wdata & `BASE_OFS_MASK;
      if (segc_we)
        segc[cur.addr[5:2]] <= cur.data & `SEGC_MASK;
    end
  end

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst || minor_rst);
  logic take_f, take_o;
  assign take_f = state == ST_IDLE && fetch_req;
  assign take_o = state == ST_IDLE && !fetch_req && op_req;
  // the one control register that an operand would touch
  logic [31:0] segc_pick;
  assign segc_pick = segc[cur.addr[5:2]];
  sequence s_split;
    take_f && fetch_cont && src_int != last_int;
  endsequence
  sequence s_fault_answer;
    fetch_ack && fetch_fault ##1 !fetch_ack;
  endsequence
  property p_split_faults;
    s_split |=> s_fault_answer;
  endproperty
  a_split_faults: assert property (p_split_faults)
    else $error("split fetch not faulted");
  property p_seg_internal;
    take_f && seg_any && !fetch_cont |=> fetch_ack && !ext_req;
  endproperty
  a_seg_internal: assert property (p_seg_internal)
    else $error("overlay fetch went outside");
  property p_ovl_op_blocked;
    take_o && in_ovl && any_en |=> op_ack && op_err;
  endproperty
  a_ovl_op_blocked: assert property (p_ovl_op_blocked)
    else $error("operand reached enabled overlay");
  property p_nonmaster_seg;
    take_o && in_segc && cur.we && op_ctx != `MASTER_CTX
      |=> op_err && segc[$past(cur.addr[5:2])] == $past(segc_pick);
  endproperty
  a_nonmaster_seg: assert property (p_nonmaster_seg)
    else $error("non-master changed segment control");
  property p_locked_seg;
    take_o && in_segc && cur.we && config_write_lock[`LOCK_BIT]
      |=> op_err && segc[$past(cur.addr[5:2])] == $past(segc_pick);
  endproperty
  a_locked_seg: assert property (p_locked_seg)
    else $error("locked segment control written");
  property p_seg_reserved;
    take_o && in_segc |=> op_ack && op_rdata[10:1] == 10'h0;
  endproperty
  a_seg_reserved: assert property (p_seg_reserved)
    else $error("segment reserved bits set");
  property p_long_swap;
    take_o && !internal && cur.we && cur.size == SZ_LONG && flip
      |=> ext_req && ext_wdata[31:24] == $past(op_acc.data[7:0])
          && ext_wdata[7:0] == $past(op_acc.data[31:24]);
  endproperty
  a_long_swap: assert property (p_long_swap)
    else $error("long word not reversed");
  property p_byte_pass;
    take_o && !internal && cur.we && cur.size == SZ_BYTE
      |=> ext_wdata == $past(op_acc.data);
  endproperty
  a_byte_pass: assert property (p_byte_pass)
    else $error("byte data altered");
  property p_master_only;
    ctl_req && !ctl_ack && ctl_we && ctl_code == `CTL_LOCK && !is_master
      |=> ctl_ack && ctl_err && $stable(config_write_lock);
  endproperty
  a_master_only: assert property (p_master_only)
    else $error("lock written by non-master");
endmodule

// ### ext_mem_model.sv
// off-chip memory model answering the block's external bus
`timescale 1ns/100ps
module ext_mem_model (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        slow,
  input  wire logic        ext_req,
  input  wire logic        ext_we,
  input  wire logic [30:0] ext_addr,
  input  wire logic [31:0] ext_wdata,
  output logic             ext_ack,
  output logic [31:0]      ext_rdata,
  output logic [30:0]      last_addr,
  output logic [31:0]      last_wdata
);
  logic [31:0] mem [16]; // tiny word store, wraps on addr 5:2
  logic [3:0]  cnt;      // wait states served so far
  // one wait state; slow mode stretches it to six to test waiting
  always_ff @(posedge clk_sys) begin
    ext_ack <= 1'b0;
    if (rst) begin
      cnt       <= 4'h0;
      ext_rdata <= 32'h0;
    end else if (ext_req && !ext_ack) begin
      if (cnt >= (slow ? 4'h6 : 4'h1)) begin
        ext_ack    <= 1'b1;
        cnt        <= 4'h0;
        last_addr  <= ext_addr;
        last_wdata <= ext_wdata;
        if (ext_we)
          mem[ext_addr[5:2]] <= ext_wdata;
        else
          ext_rdata <= mem[ext_addr[5:2]];
      end else
        cnt <= cnt + 4'h1;
    end else if (!ext_ack)
      ext_rdata <= ~ext_rdata; // released bus inverts its last data every cycle
  end
endmodule

// ### testbench.sv
// self-checking bench for the code overlay and byte-order block
`timescale 1ns/100ps
`include "code_overlay_regs.svh"
module testbench;
  import code_overlay_pkg::*;
  logic        clk_sys, rst, minor_rst, slow;
  logic        fetch_req, fetch_cont, fetch_ack, fetch_fault;
  logic        op_req, op_ack, op_err, ctl_req, ctl_we, ctl_ack;
  logic        ctl_err, ext_req, ext_we, ext_ack, er;
  logic [31:0] fetch_addr, fetch_data, op_rdata, ctl_wdata;
  logic [31:0] ctl_rdata, ext_wdata, ext_rdata, last_wdata, rd;
  logic [30:0] ext_addr, last_addr;
  logic [11:0] ctl_code;
  logic [2:0]  op_ctx, ctl_ctx;
  acc_t        op_acc;
  acc_size_t   ext_size;
  int          miscompares, num_checks, cycles, ext_cnt;
  localparam logic [31:0] SEGC = 32'h001a_1200; // segment control 0
  code_overlay_and_endian_swap #(.USP_RESET_STEP(32'h0000_0100)) dut (
    .clk_sys(clk_sys), .rst(rst), .minor_rst(minor_rst),
    .fetch_req(fetch_req), .fetch_addr(fetch_addr),
    .fetch_cont(fetch_cont), .fetch_ack(fetch_ack),
    .fetch_fault(fetch_fault), .fetch_data(fetch_data),
    .op_req(op_req), .op_acc(op_acc), .op_ctx(op_ctx),
    .op_ack(op_ack), .op_err(op_err), .op_rdata(op_rdata),
    .ctl_req(ctl_req), .ctl_we(ctl_we), .ctl_code(ctl_code),
    .ctl_ctx(ctl_ctx), .ctl_wdata(ctl_wdata), .ctl_ack(ctl_ack),
    .ctl_err(ctl_err), .ctl_rdata(ctl_rdata), .ext_req(ext_req),
    .ext_we(ext_we), .ext_size(ext_size), .ext_addr(ext_addr),
    .ext_wdata(ext_wdata), .ext_ack(ext_ack), .ext_rdata(ext_rdata));
  ext_mem_model far_mem (
    .clk_sys(clk_sys), .rst(rst), .slow(slow), .ext_req(ext_req),
    .ext_we(ext_we), .ext_addr(ext_addr), .ext_wdata(ext_wdata),
    .ext_ack(ext_ack), .ext_rdata(ext_rdata),
    .last_addr(last_addr), .last_wdata(last_wdata));
  // 125 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // hang guard and external cycle counter
  always @(posedge clk_sys) begin
    cycles++;
    if (ext_req === 1'b1)
      ext_cnt++;
    if (cycles == 20000) begin
      miscompares++;
      close_out();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // operand access; request held until the ack, dropped after it
  task automatic op(input logic we, input acc_size_t sz,
                    input logic [31:0] a, d, input logic [2:0] cx);
    @(posedge clk_sys);
    op_req <= 1'b1;
    op_acc <= '{we, sz, a, d};
    op_ctx <= cx;
    for (int i = 0; i < 40; i++) begin
      @(negedge clk_sys);
      if (op_ack === 1'b1)
        break;
    end
    rd = op_rdata;
    er = op_err;
    chk("op_ack", 32'h1, {31'h0, op_ack});
    @(posedge clk_sys);
    op_req <= 1'b0;
  endtask
  // instruction fetch, cont marks a later word of one instruction
  task automatic fetch(input logic [31:0] a, input logic cont);
    @(posedge clk_sys);
    fetch_req  <= 1'b1;
    fetch_addr <= a;
    fetch_cont <= cont;
    for (int i = 0; i < 40; i++) begin
      @(negedge clk_sys);
      if (fetch_ack === 1'b1)
        break;
    end
    rd = fetch_data;
    er = fetch_fault;
    chk("fetch_ack", 32'h1, {31'h0, fetch_ack});
    @(posedge clk_sys);
    fetch_req <= 1'b0;
  endtask
  // control-move access
  task automatic ctl(input logic we, input logic [11:0] c,
                     input logic [2:0] cx, input logic [31:0] d);
    @(posedge clk_sys);
    ctl_req   <= 1'b1;
    ctl_we    <= we;
    ctl_code  <= c;
    ctl_ctx   <= cx;
    ctl_wdata <= d;
    for (int i = 0; i < 10; i++) begin
      @(negedge clk_sys);
      if (ctl_ack === 1'b1)
        break;
    end
    rd = ctl_rdata;
    er = ctl_err;
    chk("ctl_ack", 32'h1, {31'h0, ctl_ack});
    @(posedge clk_sys);
    ctl_req <= 1'b0;
  endtask
  // reset values, minor reset, master-only codes, relocation
  task automatic t_ctl_regs();
    ctl(0, `CTL_BASE_OFS, 3'h0, 0);
    chk("ofs reset", 32'h0010_0000, rd);
    ctl(0, `CTL_LOCK, 3'h0, 0);
    chk("lock reset", 32'h0, rd);
    ctl(0, `CTL_USER_SP, 3'h2, 0);
    chk("usp reset", 32'h0000_0200, rd);
    ctl(0, `CTL_VEC_BASE, 3'h1, 0);
    chk("vec reset", 32'h0, rd);
    ctl(1, `CTL_VEC_BASE, 3'h1, 32'h1234_5fff);
    ctl(1, `CTL_SRC_FC, 3'h1, 32'h0000_00ff);
    ctl(1, `CTL_DST_FC, 3'h1, 32'h0000_0005);
    ctl(1, `CTL_USER_SP, 3'h1, 32'h0000_4444);
    @(posedge clk_sys);
    minor_rst <= 1'b1;
    @(posedge clk_sys);
    minor_rst <= 1'b0;
    ctl(0, `CTL_VEC_BASE, 3'h1, 0);
    chk("vec kept", 32'h1234_5c00, rd);
    ctl(0, `CTL_SRC_FC, 3'h1, 0);
    chk("src fc kept", 32'h7, rd);
    ctl(0, `CTL_DST_FC, 3'h1, 0);
    chk("dst fc kept", 32'h5, rd);
    ctl(0, `CTL_USER_SP, 3'h1, 0);
    chk("usp kept", 32'h0000_4444, rd);
    ctl(1, `CTL_BASE_OFS, 3'h1, 32'h0030_0000);
    chk("ofs ctx1 err", 32'h1, {31'h0, er});
    ctl(1, `CTL_BASE_OFS, 3'h0, 32'h0030_0000);
    op(1, SZ_LONG, 32'h0030_0010, 32'ha5a5_0f0f, 3'h0);
    op(0, SZ_LONG, 32'h0030_0010, 0, 3'h0);
    chk("relocated", 32'ha5a5_0f0f, rd);
    ctl(1, `CTL_BASE_OFS, 3'h0, 32'h0010_0000);
  endtask
  // byte-order reversal on internal data memory
  task automatic t_endian();
    op(1, SZ_LONG, 32'h0010_0000, 32'h1234_5678, 3'h0);
    op(0, SZ_LONG, 32'h8010_0000, 0, 3'h0);
    chk("long swap", 32'h7856_3412, rd);
    op(0, SZ_WORD, 32'h8010_0000, 0, 3'h0);
    chk("word swap", 32'h3412, {16'h0, rd[31:16]});
    op(0, SZ_BYTE, 32'h8010_0001, 0, 3'h3);
    chk("byte same", 32'h34, {24'h0, rd[23:16]});
    op(0, SZ_LONG, 32'h0010_5ffc, 0, 3'h0);
    chk("top of ram", 32'h0, {31'h0, er});
    op(0, SZ_LONG, 32'h0010_6000, 0, 3'h0);
    chk("past ram", 32'h1, {31'h0, er});
  endtask
  // external cycles: 31 address bits, swapped data, slow partner
  task automatic t_external();
    slow <= 1'b1;
    op(1, SZ_LONG, 32'hc000_0040, 32'h1122_3344, 3'h0);
    chk("ext addr", 32'h4000_0040, {1'b0, last_addr});
    chk("ext wdata", 32'h4433_2211, last_wdata);
    slow <= 1'b0;
    op(0, SZ_LONG, 32'h4000_0040, 0, 3'h0);
    chk("ext read", 32'h4433_2211, rd);
    op(1, SZ_WORD, 32'h8000_0042, 32'h5678_1234, 3'h0);
    chk("ext size", 32'(SZ_WORD), 32'(ext_size));
    chk("ext word swap", 32'h3412, {16'h0, last_wdata[15:0]});
  endtask
  // overlay segments: control regs, fetch serving, faults, lock
  task automatic t_overlay();
    int n;
    for (int s = 0; s < 16; s++) begin
      op(1, SZ_LONG, SEGC + 32'(4 * s), 32'(s) << 11 | 32'h7fe, 3'h0);
      op(0, SZ_LONG, SEGC + 32'(4 * s), 0, 3'h0);
      chk("segc", 32'(s) << 11, rd);
    end
    op(1, SZ_LONG, 32'h0018_1800, 32'hcafe_0003, 3'h0);
    op(1, SZ_LONG, 32'h0018_2000, 32'hcafe_0004, 3'h0);
    op(0, SZ_LONG, 32'h0018_1800, 0, 3'h0);
    chk("ovl as ram", 32'hcafe_0003, rd);
    op(1, SZ_LONG, SEGC + 32'hc, 32'h0022_1801, 3'h1);
    chk("segc ctx1", 32'h1, {31'h0, er});
    op(1, SZ_LONG, SEGC + 32'h10, 32'h0022_1801, 3'h0);
    n = ext_cnt;
    fetch(32'h0022_1800, 1'b0);
    chk("seg4 fetch", 32'hcafe_0004, rd);
    chk("no ext", 32'(n), 32'(ext_cnt));
    op(1, SZ_LONG, SEGC + 32'hc, 32'h0022_1801, 3'h0);
    fetch(32'h0022_1800, 1'b0);
    chk("lowest seg", 32'hcafe_0003, rd);
    op(0, SZ_LONG, 32'h0018_1800, 0, 3'h0);
    chk("ovl no data", 32'h1, {31'h0, er});
    fetch(32'h0022_17fc, 1'b0);
    fetch(32'h0022_1800, 1'b1);
    chk("straddle", 32'h1, {31'h0, er});
    fetch(32'h0022_1804, 1'b0);
    fetch(32'h0022_1808, 1'b1);
    chk("no straddle", 32'h0, {31'h0, er});
    ctl(1, `CTL_LOCK, 3'h0, 32'h1);
    op(1, SZ_LONG, SEGC + 32'hc, 32'h0, 3'h0);
    chk("locked err", 32'h1, {31'h0, er});
    op(0, SZ_LONG, SEGC + 32'hc, 0, 3'h0);
    chk("locked kept", 32'h0022_1801, rd);
    ctl(1, `CTL_LOCK, 3'h0, 32'h0);
  endtask
  task automatic close_out();
    if (miscompares == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // reset, then the scenarios in turn
  initial begin
    {rst, minor_rst, slow, fetch_req, fetch_cont, op_req} = 6'h20;
    {ctl_req, ctl_we, ctl_code, ctl_ctx, ctl_wdata} = '0;
    {fetch_addr, op_acc, op_ctx} = '0;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    t_ctl_regs();
    t_endian();
    t_external();
    t_overlay();
    close_out();
  end
endmodule
